// ==== hw/pai_pkg.sv ====
// constants, types and helpers shared by the pcm audio input port
package pai_pkg;

	// ----------------------------------------------------------------
	// initialization and clock ratio
	// ----------------------------------------------------------------
	localparam int INIT_CYCLES = 1024;
	localparam int INIT_CNT_W = 11;
	localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);
	localparam int PER_W = 12;
	localparam int BIT_W = 8;
	localparam logic [11:0] RATIO_MIN = 12'h080;
	localparam logic [11:0] RATIO_MAX = 12'h300;
	localparam logic [11:0] RATIO_OSR128_MIN = 12'h100;
	localparam logic [11:0] DRIFT_BITS = 12'h006;
	localparam logic [11:0] PER_SAT = 12'hFFF;
	localparam logic [7:0] BIT_SAT = 8'hFF;

	// ----------------------------------------------------------------
	// frame formats
	// ----------------------------------------------------------------
	localparam logic [2:0] FMT_RJ16 = 3'h0;
	localparam logic [2:0] FMT_RJ20 = 3'h1;
	localparam logic [2:0] FMT_RJ24 = 3'h2;
	localparam logic [2:0] FMT_LJ24 = 3'h3;
	localparam logic [2:0] FMT_I2S16 = 3'h4;
	localparam logic [2:0] FMT_I2S24 = 3'h5;
	localparam logic [2:0] FMT_DEFAULT = FMT_I2S24;
	localparam int SAMPLE_W = 24;
	localparam logic [4:0] SAMPLE_W5 = 5'h18;
	localparam logic [5:0] BIT_IDX_SAT = 6'h3F;

	typedef enum logic [1:0] {
		PAI_ST_INIT,
		PAI_ST_ACQ,
		PAI_ST_RUN
	} pai_state_e;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// unused codes fall back to the default framing
	function automatic logic [4:0] fmt_width(input logic [2:0] f);
		case (f)
			FMT_RJ16, FMT_I2S16: fmt_width = 5'h10;
			FMT_RJ20: fmt_width = 5'h14;
			default: fmt_width = 5'h18;
		endcase
	endfunction

	function automatic logic fmt_is_rj(input logic [2:0] f);
		fmt_is_rj = (f == FMT_RJ16) || (f == FMT_RJ20) || (f == FMT_RJ24);
	endfunction

	function automatic logic fmt_is_i2s(input logic [2:0] f);
		fmt_is_i2s = !fmt_is_rj(f) && (f != FMT_LJ24);
	endfunction

	function automatic logic [11:0] absdiff(input logic [11:0] a, input logic [11:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

endpackage

// ==== hw/pai_link_if.sv ====
// bundle between the port front end and the frame shifter
`timescale 1ns/1ns
`default_nettype none
interface pai_link_if;
	logic bit_rise;
	logic word_lvl;
	logic data_bit;
	logic enable;
	logic [2:0] fmt;
	logic [23:0] left;
	logic [23:0] right;
	logic strobe;
	modport drv(output bit_rise, output word_lvl, output data_bit, output enable, output fmt,
		input left, input right, input strobe);
	modport rcv(input bit_rise, input word_lvl, input data_bit, input enable, input fmt,
		output left, output right, output strobe);
endinterface
`default_nettype wire

// ==== hw/pai_shift.sv ====
// serial frame shifter: bit capture, word alignment, channel split
`timescale 1ns/1ns
`default_nettype none
module pai_shift (
	input wire logic clk_sys,
	input wire logic rst_s_n,
	pai_link_if.rcv lnk
);
	logic [23:0] shreg_q, shreg_d;
	logic [23:0] left_q, left_d;
	logic [23:0] right_q, right_d;
	logic [5:0] cnt_q, cnt_d;
	logic lr_q, lr_d;
	logic started_q, started_d;
	logic strobe_q, strobe_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0] w;
		logic rj;
		logic i2s;
		logic chg;
		logic [5:0] idx;
		logic [5:0] tgt;
		logic [23:0] word;
		w = pai_pkg::fmt_width(lnk.fmt);
		rj = pai_pkg::fmt_is_rj(lnk.fmt);
		i2s = pai_pkg::fmt_is_i2s(lnk.fmt);
		chg = lnk.word_lvl != lr_q;
		idx = chg ? 6'h00 : cnt_q;
		tgt = i2s ? {1'b0, w} : ({1'b0, w} - 6'h01);
		word = 24'h000000;
		shreg_d = shreg_q;
		left_d = left_q;
		right_d = right_q;
		cnt_d = cnt_q;
		lr_d = lr_q;
		started_d = started_q;
		strobe_d = 1'b0;
		if (!lnk.enable) begin
			// idle or resync: drop the line, feed zeros downstream [RQ19] [RQ10]
			shreg_d = 24'h000000;
			left_d = 24'h000000;
			right_d = 24'h000000;
			cnt_d = 6'h00;
			started_d = 1'b0;
			lr_d = lnk.word_lvl;
		end else if (lnk.bit_rise) begin
			shreg_d = {shreg_q[22:0], lnk.data_bit}; // [RQ8]
			lr_d = lnk.word_lvl;
			cnt_d = (idx == pai_pkg::BIT_IDX_SAT) ? idx : idx + 6'h01;
			if (chg) begin
				started_d = 1'b1;
			end
			if (rj && chg && started_q) begin
				// lsb sat in the last bit before the word clock flipped [RQ18]
				word = shreg_q << (pai_pkg::SAMPLE_W5 - w); // [RQ13]
				// high means left for right-justified [RQ14]
				if (lr_q) begin
					left_d = word;
				end else begin
					right_d = word;
				end
				strobe_d = 1'b1;
			end else if (!rj && (started_q || chg) && idx == tgt) begin
				// msb at first bit, one bit later for i2s [RQ18] [RQ17]
				word = shreg_d << (pai_pkg::SAMPLE_W5 - w); // [RQ13]
				// i2s low is left, left-justified high is left [RQ16] [RQ15]
				if (i2s ? !lnk.word_lvl : lnk.word_lvl) begin
					left_d = word;
				end else begin
					right_d = word;
				end
				strobe_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			shreg_q <= 24'h000000;
			left_q <= 24'h000000;
			right_q <= 24'h000000;
			cnt_q <= 6'h00;
			lr_q <= 1'b0;
			started_q <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			shreg_q <= shreg_d;
			left_q <= left_d;
			right_q <= right_d;
			cnt_q <= cnt_d;
			lr_q <= lr_d;
			started_q <= started_d;
			strobe_q <= strobe_d;
		end
	end

	assign lnk.left = left_q;
	assign lnk.right = right_q;
	assign lnk.strobe = strobe_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_bit_sample;
		@(posedge clk_sys) disable iff (!rst_s_n)
		lnk.enable && lnk.bit_rise |=> shreg_q[0] == $past(lnk.data_bit);
	endproperty
	a_bit_sample: assert property (p_bit_sample) else $error("bit not sampled on rise"); // [RQ8]

	property p_zero_idle;
		@(posedge clk_sys) disable iff (!rst_s_n)
		!lnk.enable |=> left_q == 24'h000000 && right_q == 24'h000000 && !strobe_q;
	endproperty
	a_zero_idle: assert property (p_zero_idle) else $error("samples not zero while idle"); // [RQ19]

	property p_strobe_cause;
		@(posedge clk_sys) disable iff (!rst_s_n)
		strobe_q |-> $past(lnk.bit_rise) && $past(lnk.enable);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without bit edge"); // [RQ18]

	c_strobe_i2s: cover property (@(posedge clk_sys) disable iff (!rst_s_n)
		strobe_q && lnk.fmt == pai_pkg::FMT_I2S24);
	c_strobe_rj: cover property (@(posedge clk_sys) disable iff (!rst_s_n)
		strobe_q && lnk.fmt == pai_pkg::FMT_RJ16);
endmodule
`default_nettype wire

// ==== hw/pai_top.sv ====
// pcm audio input port: reset init, clock ratio lock, slip watch, serial intake
//
// What this block does
// (RQ1) lock automatically to system-clock-to-word ratios from 128 to 768.
// (RQ2) far side supplies a supported ratio; no 512 or 768 at 192 kHz.
// (RQ3) with 128x modulator rate the ratio must exceed 256.
// (RQ4) after power-on, count 1024 system clocks before normal operation.
// (RQ5) when initialization ends every mode setting holds its default.
// (RQ6) external reset is held low at least 20 ns by the controller.
// (RQ7) reset release starts the same 1024-clock initialization.
// (RQ8) serial data is taken on each rising edge of the bit clock.
// (RQ9) word clock is frequency-locked to the system clock; any phase is fine.
// (RQ10) slip beyond six bit clocks reinitializes within one sample; output zero.
// (RQ11) frame format comes from a three-bit format select.
// (RQ12) format defaults to 24-bit i2s after reset.
// (RQ13) samples are two's complement, msb first.
// (RQ14) right-justified: word clock high is left, low is right.
// (RQ15) left-justified: word clock high is left, low is right.
// (RQ16) i2s: word clock low is left, high is right.
// (RQ17) formats: rj 16/20/24, lj 24, i2s 16/24.
// (RQ18) lj msb after edge, i2s one bit later, rj lsb before edge.
// (RQ19) during init or resync ignore input and emit zero samples.
`timescale 1ns/1ns
`default_nettype none
module pai_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pcm_bit_clock,
	input wire logic pcm_word_clock,
	input wire logic pcm_serial_in,
	input wire logic [2:0] frame_format_select,
	input wire logic format_load,
	input wire logic osr_128_sel,
	output logic [23:0] sample_left,
	output logic [23:0] sample_right,
	output logic sample_valid,
	output logic port_running,
	output logic [11:0] ratio_cycles
);
	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_m_q, rst_s_n;
	logic [2:0] bck_q, wck_q;
	logic [1:0] dat_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_n <= rst_m_q;
		end
	end

	// stage 0 is read only by stage 1; edges come from stages 1 and 2
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			bck_q <= 3'h0;
			wck_q <= 3'h0;
			dat_q <= 2'h0;
		end else begin
			bck_q <= {bck_q[1:0], pcm_bit_clock};
			wck_q <= {wck_q[1:0], pcm_word_clock};
			dat_q <= {dat_q[0], pcm_serial_in};
		end
	end

	logic bit_rise, word_rise;
	assign bit_rise = bck_q[1] && !bck_q[2];
	assign word_rise = wck_q[1] && !wck_q[2];

	// ----------------------------------------------------------------
	// init, ratio lock and slip watch
	// ----------------------------------------------------------------
	pai_pkg::pai_state_e state_q, state_d;
	logic [10:0] init_cnt_q, init_cnt_d;
	logic [11:0] per_cnt_q, per_cnt_d;
	logic [11:0] per_q, per_d;
	logic [7:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] bit_q, bit_d;
	logic acq_ok_q, acq_ok_d;
	logic [2:0] fmt_q, fmt_d;
	logic [11:0] drift_tol;
	logic in_range;

	// slip limit scales with the measured bit period, so any frame length works
	assign drift_tol = {4'h0, bit_q} * pai_pkg::DRIFT_BITS;
	// only the period matters; the phase to the system clock is free [RQ9]
	assign in_range = per_cnt_q >= pai_pkg::RATIO_MIN && per_cnt_q <= pai_pkg::RATIO_MAX
		&& (!osr_128_sel || per_cnt_q > pai_pkg::RATIO_OSR128_MIN); // [RQ1] [RQ3]

	always_comb begin
		state_d = state_q;
		init_cnt_d = init_cnt_q;
		per_cnt_d = (per_cnt_q == pai_pkg::PER_SAT) ? per_cnt_q : per_cnt_q + 12'h001;
		per_d = per_q;
		bit_cnt_d = (bit_cnt_q == pai_pkg::BIT_SAT) ? bit_cnt_q : bit_cnt_q + 8'h01;
		bit_d = bit_q;
		acq_ok_d = acq_ok_q;
		fmt_d = fmt_q;
		if (bit_rise) begin
			bit_d = bit_cnt_q;
			bit_cnt_d = 8'h01;
		end
		if (word_rise) begin
			per_cnt_d = 12'h001;
		end
		if (format_load && state_q != pai_pkg::PAI_ST_INIT) begin
			fmt_d = frame_format_select; // [RQ11]
		end
		case (state_q)
			pai_pkg::PAI_ST_INIT: begin
				// fixed-length init after reset release [RQ4] [RQ7]
				fmt_d = pai_pkg::FMT_DEFAULT; // [RQ5] [RQ12]
				acq_ok_d = 1'b0;
				init_cnt_d = init_cnt_q + 11'h001;
				if (init_cnt_q == pai_pkg::INIT_LAST) begin
					state_d = pai_pkg::PAI_ST_ACQ;
				end
			end
			pai_pkg::PAI_ST_ACQ: begin
				// two matching in-range periods before the port opens [RQ1]
				if (word_rise) begin
					per_d = per_cnt_q;
					acq_ok_d = in_range;
					if (in_range && acq_ok_q
						&& pai_pkg::absdiff(per_cnt_q, per_q) <= {4'h0, bit_q}) begin
						state_d = pai_pkg::PAI_ST_RUN;
					end
				end
			end
			pai_pkg::PAI_ST_RUN: begin
				// slip or lost word clock drops back to resync [RQ10]
				if (word_rise && pai_pkg::absdiff(per_cnt_q, per_q) > drift_tol) begin
					state_d = pai_pkg::PAI_ST_ACQ;
					acq_ok_d = 1'b0;
				end else if (!word_rise && per_cnt_q > per_q + drift_tol) begin
					state_d = pai_pkg::PAI_ST_ACQ;
					acq_ok_d = 1'b0;
				end
			end
			default: begin
				state_d = pai_pkg::PAI_ST_INIT;
				init_cnt_d = 11'h000;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			state_q <= pai_pkg::PAI_ST_INIT;
			init_cnt_q <= 11'h000;
			per_cnt_q <= 12'h000;
			per_q <= 12'h000;
			bit_cnt_q <= 8'h00;
			bit_q <= 8'h00;
			acq_ok_q <= 1'b0;
			fmt_q <= pai_pkg::FMT_DEFAULT;
		end else begin
			state_q <= state_d;
			init_cnt_q <= init_cnt_d;
			per_cnt_q <= per_cnt_d;
			per_q <= per_d;
			bit_cnt_q <= bit_cnt_d;
			bit_q <= bit_d;
			acq_ok_q <= acq_ok_d;
			fmt_q <= fmt_d;
		end
	end

	// ----------------------------------------------------------------
	// frame shifter
	// ----------------------------------------------------------------
	pai_link_if lnk ();

	assign lnk.bit_rise = bit_rise;
	assign lnk.word_lvl = wck_q[1];
	// data is two stages deep, like the clock edge it is sampled on
	assign lnk.data_bit = dat_q[1];
	assign lnk.enable = state_q == pai_pkg::PAI_ST_RUN; // [RQ19]
	assign lnk.fmt = fmt_q;

	pai_shift u_shift (
		.clk_sys(clk_sys),
		.rst_s_n(rst_s_n),
		.lnk(lnk.rcv)
	);

	assign sample_left = lnk.left;
	assign sample_right = lnk.right;
	assign sample_valid = lnk.strobe;
	assign port_running = state_q == pai_pkg::PAI_ST_RUN;
	assign ratio_cycles = per_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_init_hold;
		@(posedge clk_sys) disable iff (!rst_s_n)
		$rose(rst_s_n) |-> state_q == pai_pkg::PAI_ST_INIT [*8];
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("init left early"); // [RQ7]

	property p_init_len;
		@(posedge clk_sys) disable iff (!rst_s_n)
		state_q == pai_pkg::PAI_ST_INIT |=>
			state_q == (($past(init_cnt_q) == pai_pkg::INIT_LAST)
			? pai_pkg::PAI_ST_ACQ : pai_pkg::PAI_ST_INIT);
	endproperty
	a_init_len: assert property (p_init_len) else $error("init length wrong"); // [RQ4]

	property p_default_fmt;
		@(posedge clk_sys) disable iff (!rst_s_n)
		state_q == pai_pkg::PAI_ST_INIT ##1 state_q == pai_pkg::PAI_ST_ACQ
			|-> fmt_q == pai_pkg::FMT_DEFAULT;
	endproperty
	a_default_fmt: assert property (p_default_fmt) else $error("format not default"); // [RQ12]

	property p_lock_range;
		@(posedge clk_sys) disable iff (!rst_s_n)
		state_q == pai_pkg::PAI_ST_ACQ ##1 state_q == pai_pkg::PAI_ST_RUN
			|-> per_q >= pai_pkg::RATIO_MIN && per_q <= pai_pkg::RATIO_MAX;
	endproperty
	a_lock_range: assert property (p_lock_range) else $error("locked out of range"); // [RQ1]

	property p_slip;
		@(posedge clk_sys) disable iff (!rst_s_n)
		state_q == pai_pkg::PAI_ST_RUN && word_rise
			&& pai_pkg::absdiff(per_cnt_q, per_q) > drift_tol
			|=> state_q == pai_pkg::PAI_ST_ACQ && !sample_valid;
	endproperty
	a_slip: assert property (p_slip) else $error("slip not caught"); // [RQ10]

	property p_lost;
		@(posedge clk_sys) disable iff (!rst_s_n)
		state_q == pai_pkg::PAI_ST_RUN && !word_rise && per_cnt_q > per_q + drift_tol
			|=> state_q == pai_pkg::PAI_ST_ACQ ##1 sample_left == 24'h000000;
	endproperty
	a_lost: assert property (p_lost) else $error("lost word clock not caught"); // [RQ10]

	c_run: cover property (@(posedge clk_sys) disable iff (!rst_s_n)
		$rose(port_running));
	c_resync: cover property (@(posedge clk_sys) disable iff (!rst_s_n)
		$fell(port_running));
endmodule
`default_nettype wire

// ==== testbench/pai_src.sv ====
// behavioural audio source driving the serial pcm pins
`timescale 1ns/1ns
`default_nettype none
module pai_src (
	input wire logic clk,
	input wire logic [2:0] fmt,
	input wire logic [23:0] left,
	input wire logic [23:0] right,
	input wire logic [5:0] half_bits,
	input wire logic [3:0] extra,
	output logic bck,
	output logic lrck,
	output logic dat
);
	int w;
	int n;
	int idx;
	logic [23:0] word;
	// ----------------------------------------------------------------
	// frame generator, bit clock of 12 system clocks
	// ----------------------------------------------------------------
	// frames back to back at fixed length keep the word clock locked
	initial begin
		bck = 1'b0;
		lrck = 1'b0;
		dat = 1'b0;
		// let the bench set its knobs first; a zero half length would spin forever
		@(negedge clk);
		forever begin
			for (int h = 0; h < 2; h++) begin
				// extra slots stretch one half on purpose to force a slip
				n = int'(half_bits) + ((h == 0) ? int'(extra) : 0);
				for (int k = 0; k < n; k++) begin
					w = (fmt == 3'h0 || fmt == 3'h4) ? 16 : ((fmt == 3'h1) ? 20 : 24);
					idx = (fmt <= 3'h2) ? k - (n - w) : ((fmt == 3'h3) ? k : k - 1);
					word = (h == 1) ? right : left;
					bck = 1'b0;
					lrck = (fmt >= 3'h4) ? (h == 1) : (h == 0);
					// msb first; unused slots toggle so a stale bit never passes
					dat = (idx >= 0 && idx < w) ? word[w - 1 - idx] : k[0];
					repeat (6) @(negedge clk);
					bck = 1'b1;
					repeat (6) @(negedge clk);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/pai_top_tb.sv ====
// self-checking bench for the pcm audio input port
`timescale 1ns/1ns
`default_nettype none
module pai_top_tb;
	logic clk_sys;
	logic rst_n;
	logic bck;
	logic lrck;
	logic dat;
	logic [2:0] fsel;
	logic fload;
	logic osr;
	logic [2:0] sfmt;
	logic [23:0] sl;
	logic [23:0] sr;
	logic [5:0] hb;
	logic [3:0] ex;
	logic [23:0] sample_left;
	logic [23:0] sample_right;
	logic sample_valid;
	logic port_running;
	logic [11:0] ratio_cycles;
	int err_count;
	int checked;
	int pulses;

	pai_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .pcm_bit_clock(bck),
		.pcm_word_clock(lrck), .pcm_serial_in(dat), .frame_format_select(fsel),
		.format_load(fload), .osr_128_sel(osr), .sample_left(sample_left),
		.sample_right(sample_right), .sample_valid(sample_valid),
		.port_running(port_running), .ratio_cycles(ratio_cycles));
	pai_src src (.clk(clk_sys), .fmt(sfmt), .left(sl), .right(sr), .half_bits(hb),
		.extra(ex), .bck(bck), .lrck(lrck), .dat(dat));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (sample_valid === 1'b1) pulses++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// bounded wait; running out ends the run
	task automatic wait_run(input logic v, input int lim);
		for (int i = 0; i < lim && port_running !== v; i++) cyc(1);
		if (port_running !== v) begin
			check(24'(port_running), 24'(v));
			print_verdict();
		end
	endtask
	// narrow words come out msb-aligned with zero padding
	function automatic logic [23:0] exp_word(input logic [2:0] f, input logic [23:0] v);
		int w;
		w = (f == 3'h0 || f == 3'h4) ? 16 : ((f == 3'h1) ? 20 : 24);
		return v << (24 - w);
	endfunction
	// just short of the 1024 init cycles; the first frame may overlap init
	task automatic restart;
		rst_n = 1'b1;
		cyc(1020);
		check(24'(port_running), 24'h0); // still initialising
		check(sample_left, 24'h0); // input ignored
		wait_run(1'b1, 3000);
		check(24'(ratio_cycles), 24'h300); // ratio found
	endtask
	task automatic run_fmt(input logic [2:0] f, input logic ld);
		sl = 24'($urandom());
		sr = 24'($urandom());
		sfmt = f;
		if (ld) begin
			fsel = f;
			fload = 1'b1;
			cyc(1);
			fload = 1'b0;
		end
		// a polarity swap slips the port; give it time to relock
		cyc(1600);
		wait_run(1'b1, 4000);
		cyc(2400);
		pulses = 0;
		cyc(1536);
		check(24'(pulses), 24'h4); // one word per half frame
		check(sample_left, exp_word(f, sl)); // left word
		check(sample_right, exp_word(f, sr)); // right word
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		fsel = 3'h0;
		fload = 1'b0;
		osr = 1'b0;
		sfmt = 3'h5;
		sl = 24'h0;
		sr = 24'h0;
		hb = 6'h20;
		ex = 4'h0;
		err_count = 0;
		checked = 0;
		pulses = 0;
		void'($urandom(305));
		cyc(10);
		check(24'(port_running), 24'h0); // held in reset
		restart();
		run_fmt(3'h5, 1'b0); // default framing without a load
		// spare codes 6 and 7 frame as 24-bit i2s
		for (int f = 0; f < 8; f++) run_fmt(3'(f), 1'b1); // every code
		// slip of eight bit clocks in one half
		ex = 4'h8;
		cyc(800);
		ex = 4'h0;
		wait_run(1'b0, 1200);
		cyc(2);
		check(sample_left, 24'h0); // zero while resyncing
		check(sample_right, 24'h0);
		// ratio 192 is refused with 128x modulator rate, taken without it
		osr = 1'b1;
		hb = 6'h08;
		cyc(2500);
		check(24'(port_running), 24'h0);
		osr = 1'b0;
		wait_run(1'b1, 4000);
		check(24'(ratio_cycles), 24'h0C0); // low ratio accepted
		osr = 1'b1;
		hb = 6'h20;
		cyc(1600);
		wait_run(1'b1, 4000);
		check(24'(ratio_cycles), 24'h300); // high ratio fine at 128x
		// load another format, then reset in mid-run: default must return
		fsel = 3'h3;
		fload = 1'b1;
		cyc(1);
		fload = 1'b0;
		rst_n = 1'b0;
		cyc(5); // 20 ns low, the shortest hold allowed
		check(sample_left, 24'h0); // outputs cleared in reset
		restart();
		run_fmt(3'h5, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
